// file: rtl/gpt_pkg.sv
// Purpose: constants, types and register map of the counter/timer block
// Assumes: byte-wide special-function register port, single clock
// Notes: wide timer register offsets sit in gpt_w_base plus a local offset
//
// Summary of operation
// - count only when run and gate allow, except timer b and the split high byte (b run, no gate) while timer a is split
// - counter select picks falling pin edges, except timer b's while timer a is split
// - timer b modes 13/16/8-reload/inactive
// - timer a modes 13/16/8-reload/split
// - clock select: system clock or prescaled clock
// - prescaler divides by 12, 4, 48, ext/8
// - unused clock select bits read zero
// - legacy counts read/write as two bytes
// - wide timers are 16-bit, two bytes
// - capture/reload in control, toggle in config
// - wide counter select counts pin edges
// - wide clock: /1, /2, /12, ext/8
// - decrement enable: trigger pin sets direction
// - with decrement enable, no trigger captures/reloads
// - wide overflows drive DAC triggers; wide timers 0 and 1 also drive converter triggers
// - baud ticks from legacy b and wide timers
// - 13-bit mode overflows at 0x1FFF
// - 8-bit reload from unchanged high byte
// - split high byte uses b run, b flag
// - flags set by hardware, cleared by software/vector
package gpt_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] GPT_A_MODE = 8'h89;
  localparam logic [7:0] GPT_A_TAL = 8'h8A;
  localparam logic [7:0] GPT_A_TBL = 8'h8B;
  localparam logic [7:0] GPT_A_TAH = 8'h8C;
  localparam logic [7:0] GPT_A_TBH = 8'h8D;
  localparam logic [7:0] GPT_A_CKC = 8'h8E;
  localparam logic [7:0] gpt_w_base [3] = '{8'hC0, 8'hC8, 8'hD0};
  localparam logic [2:0] GPT_W_CTL = 3'h0;
  localparam logic [2:0] GPT_W_CFG = 3'h1;
  localparam logic [2:0] GPT_W_CNL = 3'h2;
  localparam logic [2:0] GPT_W_CNH = 3'h3;
  localparam logic [2:0] GPT_W_RCL = 3'h4;
  localparam logic [2:0] GPT_W_RCH = 3'h5;
  localparam logic [7:0] GPT_RST_BYTE = 8'h00;
  // ****************************************
  // pins and timebase
  // ****************************************
  localparam int GPT_NPIN = 11;
  localparam int GPT_P_OSC = 0;
  localparam int GPT_P_IRQA = 1;
  localparam int GPT_P_IRQB = 2;
  localparam int GPT_P_CNTA = 3;
  localparam int GPT_P_CNTB = 4;
  localparam int GPT_P_WCNT = 5;
  localparam int GPT_P_WTRG = 8;
  localparam logic [5:0] GPT_DIV2 = 6'h02;
  localparam logic [5:0] GPT_DIV4 = 6'h04;
  localparam logic [5:0] GPT_DIV12 = 6'h0C;
  localparam logic [5:0] GPT_DIV48 = 6'h30;
  localparam logic [2:0] GPT_EXT_LAST = 3'h7;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {GPT_M13 = 2'h0, GPT_M16 = 2'h1, GPT_M8R = 2'h2, GPT_M3 = 2'h3} gpt_mode_e;
  typedef enum logic [1:0] {GPT_P12 = 2'h0, GPT_P4 = 2'h1, GPT_P48 = 2'h2, GPT_PEXT = 2'h3} gpt_psc_e;
  typedef enum logic [1:0] {GPT_W1 = 2'h0, GPT_W2 = 2'h1, GPT_W12 = 2'h2, GPT_WEXT = 2'h3} gpt_wclk_e;
  typedef struct packed {
    logic gate_b; logic ct_b; gpt_mode_e mode_b;
    logic gate_a; logic ct_a; gpt_mode_e mode_a;
  } gpt_lmode_s;
  typedef struct packed {
    logic [2:0] rsv_hi; logic sys_b; logic sys_a; logic rsv_lo; gpt_psc_e psc;
  } gpt_ckc_s;
  typedef struct packed {
    logic tf; logic exf; logic [1:0] rsv; logic exen; logic run; logic ct; logic cprl;
  } gpt_wctl_s;
  typedef struct packed {
    logic [2:0] rsv; gpt_wclk_e clk; logic tog; logic toe; logic down_en;
  } gpt_wcfg_s;
endpackage

// file: rtl/gpt_timers.sv
// Purpose: two legacy timers and three wide up/down timers
// Assumes: run bits and flag clears come from the timer control register
// Notes: register reads answer one cycle after sfr_rd
`timescale 1ns/100ps
module gpt_timers import gpt_pkg::*; (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // legacy run bits and flag control
  input wire logic timer_a_run,
  input wire logic timer_b_run,
  input wire logic tf_a_clr,
  input wire logic tf_b_clr,
  input wire logic vec_a_ack,
  input wire logic vec_b_ack,
  output logic timer_a_overflow_flag,
  output logic timer_b_overflow_flag,
  // pins
  input wire logic ext_osc_pin,
  input wire logic ext_irq_a_pin,
  input wire logic ext_irq_b_pin,
  input wire logic timer_a_count_pin,
  input wire logic timer_b_count_pin,
  input wire logic [2:0] wide_timer_count_pin,
  input wire logic [2:0] wide_timer_trigger_pin,
  // events
  output logic [1:0] adc_start_trig,
  output logic [2:0] dac_update_trig,
  output logic [3:0] uart0_baud_src,
  output logic uart1_baud_tick,
  output logic [2:0] wide_toggle_out
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [GPT_NPIN-1:0] pins, s1_r, s2_r, s3_r, flt_r, fltd_r, fall;
  assign pins = {wide_timer_trigger_pin, wide_timer_count_pin, timer_b_count_pin,
                 timer_a_count_pin, ext_irq_b_pin, ext_irq_a_pin, ext_osc_pin};
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      flt_r <= '0;
      fltd_r <= '0;
    end else if (ce) begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // a level is accepted only once two later stages agree
      flt_r <= (s2_r & s3_r) | (flt_r & (s2_r ^ s3_r));
      fltd_r <= flt_r;
    end
  end
  assign fall = fltd_r & ~flt_r;
  // ****************************************
  // timebase
  // ****************************************
  logic [5:0] p48_r;
  logic [2:0] e8_r;
  logic t2, t4, t12, t48, text, psc_tick;
  always_ff @(posedge mclk) begin
    if (rst) begin
      p48_r <= '0;
      e8_r <= '0;
    end else if (ce) begin
      p48_r <= (p48_r == GPT_DIV48 - 6'h01) ? 6'h00 : p48_r + 6'h01;
      if (flt_r[GPT_P_OSC] & ~fltd_r[GPT_P_OSC]) begin
        e8_r <= e8_r + 3'h1;
      end
    end
  end
  assign t2 = (p48_r % GPT_DIV2) == GPT_DIV2 - 6'h01;
  assign t4 = (p48_r % GPT_DIV4) == GPT_DIV4 - 6'h01;
  assign t12 = (p48_r % GPT_DIV12) == GPT_DIV12 - 6'h01;
  assign t48 = p48_r == GPT_DIV48 - 6'h01;
  assign text = flt_r[GPT_P_OSC] & ~fltd_r[GPT_P_OSC] & (e8_r == GPT_EXT_LAST);
  gpt_lmode_s lmode_r;
  gpt_ckc_s ckc_r;
  always_comb begin
    case (ckc_r.psc)
      GPT_P12: psc_tick = t12;
      GPT_P4: psc_tick = t4;
      GPT_P48: psc_tick = t48;
      default: psc_tick = text;
    endcase
  end
  // ****************************************
  // legacy timers
  // ****************************************
  // returns {overflow, next count} for one step in the given mode
  function automatic logic [16:0] gpt_step(input gpt_mode_e m, input logic [15:0] v);
    logic [13:0] n13;
    logic [16:0] n16;
    logic [8:0] n8;
    n13 = {1'b0, v[15:8], v[4:0]} + 14'h0001;
    n16 = {1'b0, v} + 17'h00001;
    n8 = {1'b0, v[7:0]} + 9'h001;
    case (m)
      GPT_M13: gpt_step = {n13[13], n13[12:5], v[7:5], n13[4:0]};
      GPT_M16: gpt_step = n16;
      GPT_M8R: gpt_step = n8[8] ? {1'b1, v[15:8], v[15:8]} : {1'b0, v[15:8], n8[7:0]};
      default: gpt_step = {n8[8], v[15:8], n8[7:0]};
    endcase
  endfunction
  logic [15:0] ta_r, tb_r, ta_nxt, tb_nxt;
  logic [16:0] a_st, b_st;
  logic [8:0] ah_st;
  logic a_m3, tick_a, tick_b, tick_ah, a_go, b_go, ah_go, ovf_a, ovf_b, ovf_ah;
  assign a_m3 = lmode_r.mode_a == GPT_M3;
  assign tick_a = lmode_r.ct_a ? fall[GPT_P_CNTA] : (ckc_r.sys_a | psc_tick);
  // timer b loses its pin while timer a is split
  assign tick_b = (lmode_r.ct_b & ~a_m3) ? fall[GPT_P_CNTB] : (ckc_r.sys_b | psc_tick);
  assign tick_ah = ckc_r.sys_a | psc_tick;
  assign a_go = timer_a_run & (~lmode_r.gate_a | flt_r[GPT_P_IRQA]) & tick_a;
  // while a is split, b runs on its mode alone
  assign b_go = tick_b & (lmode_r.mode_b != GPT_M3) &
                (a_m3 | (timer_b_run & (~lmode_r.gate_b | flt_r[GPT_P_IRQB])));
  assign ah_go = a_m3 & timer_b_run & tick_ah;
  assign a_st = gpt_step(lmode_r.mode_a, ta_r);
  assign b_st = gpt_step(lmode_r.mode_b, tb_r);
  assign ah_st = {1'b0, ta_r[15:8]} + 9'h001;
  assign ovf_a = a_go & a_st[16];
  assign ovf_b = b_go & b_st[16];
  assign ovf_ah = ah_go & ah_st[8];
  always_comb begin
    ta_nxt = ta_r;
    tb_nxt = tb_r;
    if (a_go) begin
      ta_nxt = a_st[15:0];
    end
    if (ah_go) begin
      ta_nxt[15:8] = ah_st[7:0];
    end
    if (b_go) begin
      tb_nxt = b_st[15:0];
    end
    // a software write wins over a count in the same cycle
    if (sfr_wr) begin
      if (sfr_addr == GPT_A_TAL) begin
        ta_nxt[7:0] = sfr_wdata;
      end else if (sfr_addr == GPT_A_TAH) begin
        ta_nxt[15:8] = sfr_wdata;
      end else if (sfr_addr == GPT_A_TBL) begin
        tb_nxt[7:0] = sfr_wdata;
      end else if (sfr_addr == GPT_A_TBH) begin
        tb_nxt[15:8] = sfr_wdata;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      ta_r <= {GPT_RST_BYTE, GPT_RST_BYTE};
      tb_r <= {GPT_RST_BYTE, GPT_RST_BYTE};
    end else if (ce) begin
      ta_r <= ta_nxt;
      tb_r <= tb_nxt;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      lmode_r <= GPT_RST_BYTE;
      ckc_r <= GPT_RST_BYTE;
    end else if (ce & sfr_wr) begin
      if (sfr_addr == GPT_A_MODE) begin
        lmode_r <= sfr_wdata;
      end else if (sfr_addr == GPT_A_CKC) begin
        ckc_r <= sfr_wdata & 8'h1B;
      end
    end
  end
  // set wins over any clear arriving in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      timer_a_overflow_flag <= 1'b0;
      timer_b_overflow_flag <= 1'b0;
    end else if (ce) begin
      timer_a_overflow_flag <= ovf_a | (timer_a_overflow_flag & ~tf_a_clr & ~vec_a_ack);
      timer_b_overflow_flag <= (a_m3 ? ovf_ah : ovf_b) |
                               (timer_b_overflow_flag & ~tf_b_clr & ~vec_b_ack);
    end
  end
  // ****************************************
  // wide timers
  // ****************************************
  logic [15:0] w_cnt_r [3];
  logic [15:0] w_rcap_r [3];
  gpt_wctl_s w_ctl_r [3];
  gpt_wcfg_s w_cfg_r [3];
  logic [2:0] w_ovf;
  for (genvar g = 0; g < 3; g++) begin : g_wide
    logic wr, tick, up, go, trg, hit, ovf;
    logic [15:0] cnt_nxt;
    assign wr = sfr_wr & (sfr_addr[7:3] == gpt_w_base[g][7:3]);
    always_comb begin
      case (w_cfg_r[g].clk)
        GPT_W1: tick = 1'b1;
        GPT_W2: tick = t2;
        GPT_W12: tick = t12;
        default: tick = text;
      endcase
      if (w_ctl_r[g].ct) begin
        tick = fall[GPT_P_WCNT+g];
      end
    end
    assign up = ~w_cfg_r[g].down_en | flt_r[GPT_P_WTRG+g];
    assign go = w_ctl_r[g].run & tick;
    // direction-only use of the trigger pin blocks captures and reloads
    assign trg = w_ctl_r[g].exen & ~w_cfg_r[g].down_en & fall[GPT_P_WTRG+g];
    assign hit = w_ctl_r[g].cprl ? (up ? &w_cnt_r[g] : ~|w_cnt_r[g])
                 : (up ? &w_cnt_r[g] : (w_cnt_r[g] == w_rcap_r[g]));
    assign ovf = go & hit;
    assign w_ovf[g] = ovf;
    always_comb begin
      cnt_nxt = w_cnt_r[g];
      if (go) begin
        if (hit & ~w_ctl_r[g].cprl) begin
          cnt_nxt = up ? w_rcap_r[g] : 16'hFFFF;
        end else begin
          cnt_nxt = up ? w_cnt_r[g] + 16'h0001 : w_cnt_r[g] - 16'h0001;
        end
      end
      if (trg & ~w_ctl_r[g].cprl) begin
        cnt_nxt = w_rcap_r[g];
      end
      if (wr & (sfr_addr[2:0] == GPT_W_CNL)) begin
        cnt_nxt[7:0] = sfr_wdata;
      end else if (wr & (sfr_addr[2:0] == GPT_W_CNH)) begin
        cnt_nxt[15:8] = sfr_wdata;
      end
    end
    always_ff @(posedge mclk) begin
      if (rst) begin
        w_cnt_r[g] <= '0;
        w_rcap_r[g] <= '0;
        w_ctl_r[g] <= GPT_RST_BYTE;
        w_cfg_r[g] <= GPT_RST_BYTE;
      end else if (ce) begin
        w_cnt_r[g] <= cnt_nxt;
        if (trg & w_ctl_r[g].cprl) begin
          w_rcap_r[g] <= w_cnt_r[g];
        end else if (wr & (sfr_addr[2:0] == GPT_W_RCL)) begin
          w_rcap_r[g][7:0] <= sfr_wdata;
        end else if (wr & (sfr_addr[2:0] == GPT_W_RCH)) begin
          w_rcap_r[g][15:8] <= sfr_wdata;
        end
        if (wr & (sfr_addr[2:0] == GPT_W_CTL)) begin
          w_ctl_r[g] <= sfr_wdata & 8'hCF;
        end
        if (ovf) begin
          w_ctl_r[g].tf <= 1'b1;
        end
        // exf toggles as a 17th bit on reload-mode overflow; a pin event sets it in either mode
        if (trg) begin
          w_ctl_r[g].exf <= 1'b1;
        end else if (ovf & ~w_ctl_r[g].cprl) begin
          w_ctl_r[g].exf <= ~w_ctl_r[g].exf;
        end
        if (wr & (sfr_addr[2:0] == GPT_W_CFG)) begin
          w_cfg_r[g] <= sfr_wdata & 8'h1F;
        end else if (ovf & w_cfg_r[g].toe) begin
          w_cfg_r[g].tog <= ~w_cfg_r[g].tog;
        end
      end
    end
  end
  // ****************************************
  // event outputs and read port
  // ****************************************
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (sfr_addr == GPT_A_MODE) begin
      rd_mux = lmode_r;
    end else if (sfr_addr == GPT_A_CKC) begin
      rd_mux = ckc_r;
    end else if (sfr_addr == GPT_A_TAL) begin
      rd_mux = ta_r[7:0];
    end else if (sfr_addr == GPT_A_TAH) begin
      rd_mux = ta_r[15:8];
    end else if (sfr_addr == GPT_A_TBL) begin
      rd_mux = tb_r[7:0];
    end else if (sfr_addr == GPT_A_TBH) begin
      rd_mux = tb_r[15:8];
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (sfr_addr[7:3] == gpt_w_base[i][7:3]) begin
          case (sfr_addr[2:0])
            GPT_W_CTL: rd_mux = w_ctl_r[i];
            GPT_W_CFG: rd_mux = w_cfg_r[i];
            GPT_W_CNL: rd_mux = w_cnt_r[i][7:0];
            GPT_W_CNH: rd_mux = w_cnt_r[i][15:8];
            GPT_W_RCL: rd_mux = w_rcap_r[i][7:0];
            GPT_W_RCH: rd_mux = w_rcap_r[i][15:8];
            default: rd_mux = 8'h00;
          endcase
        end
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
      adc_start_trig <= '0;
      dac_update_trig <= '0;
      uart0_baud_src <= '0;
      uart1_baud_tick <= 1'b0;
      wide_toggle_out <= '0;
    end else if (ce) begin
      if (sfr_rd) begin
        sfr_rdata <= rd_mux;
      end
      adc_start_trig <= w_ovf[1:0];
      dac_update_trig <= w_ovf;
      uart0_baud_src <= {w_ovf, ovf_b};
      uart1_baud_tick <= ovf_b;
      wide_toggle_out <= {w_cfg_r[2].tog, w_cfg_r[1].tog, w_cfg_r[0].tog};
    end
  end
endmodule

// file: rtl/gpt_timers_end.sv
// Purpose: none; kept empty to end file list
// Assumes: nothing
// Notes: holds no logic
`timescale 1ns/100ps

// file: tb/gpt_timers_monitor.sv
// Purpose: port checks for the timer block
// Assumes: ce high whenever reset is applied
// Notes: bind sits at the foot of this file
`timescale 1ns/100ps
module gpt_timers_monitor import gpt_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // flags
  input wire logic tf_a_clr,
  input wire logic tf_b_clr,
  input wire logic vec_a_ack,
  input wire logic vec_b_ack,
  input wire logic timer_a_overflow_flag,
  input wire logic timer_b_overflow_flag,
  // events
  input wire logic [1:0] adc_start_trig,
  input wire logic [2:0] dac_update_trig,
  input wire logic [3:0] uart0_baud_src,
  input wire logic uart1_baud_tick
);
  // ****
  // checks
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic wr_md, rd_md, wr_ck, rd_ck;
  assign wr_md = ce && sfr_wr && sfr_addr == GPT_A_MODE;
  assign rd_md = ce && sfr_rd && sfr_addr == GPT_A_MODE;
  assign wr_ck = ce && sfr_wr && sfr_addr == GPT_A_CKC;
  assign rd_ck = ce && sfr_rd && sfr_addr == GPT_A_CKC;
  a_reset_clears: assert property (disable iff (1'b0) rst && ce |=> sfr_rdata == GPT_RST_BYTE
    && !timer_a_overflow_flag && !timer_b_overflow_flag) else $error("outputs not clear after reset");
  a_mode_readback: assert property (wr_md ##1 !sfr_wr ##1 rd_md |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("mode register readback differs");
  a_clksel_mask: assert property (wr_ck ##1 !sfr_wr ##1 rd_ck |=> sfr_rdata == ($past(sfr_wdata, 3) & 8'h1B))
    else $error("clock select unused bits not zero");
  a_flag_a_cause: assert property ($fell(timer_a_overflow_flag) |-> $past(tf_a_clr) || $past(vec_a_ack))
    else $error("flag a dropped without clear");
  a_flag_b_cause: assert property ($fell(timer_b_overflow_flag) |-> $past(tf_b_clr) || $past(vec_b_ack))
    else $error("flag b dropped without clear");
  a_baud_pair: assert property (uart1_baud_tick == uart0_baud_src[0])
    else $error("baud ticks disagree");
  a_trig_pair: assert property (adc_start_trig == dac_update_trig[1:0])
    else $error("converter and dac triggers disagree");
  a_unmapped_zero: assert property (ce && sfr_rd && sfr_addr == 8'h80 |=> sfr_rdata == GPT_RST_BYTE)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (ce && !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without read");
  a_wide_rsv: assert property (ce && sfr_rd && sfr_addr == gpt_w_base[0] |=> sfr_rdata[5:4] == 2'h0)
    else $error("wide control reserved bits set");
  c_flag_a: cover property ($rose(timer_a_overflow_flag));
  c_flag_b: cover property ($rose(timer_b_overflow_flag));
  c_ck_rd: cover property (wr_ck ##2 rd_ck);
endmodule
bind gpt_timers gpt_timers_monitor gpt_timers_monitor_inst (.mclk(mclk), .rst(rst), .ce(ce),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .tf_a_clr(tf_a_clr), .tf_b_clr(tf_b_clr), .vec_a_ack(vec_a_ack), .vec_b_ack(vec_b_ack),
  .timer_a_overflow_flag(timer_a_overflow_flag), .timer_b_overflow_flag(timer_b_overflow_flag),
  .adc_start_trig(adc_start_trig), .dac_update_trig(dac_update_trig), .uart0_baud_src(uart0_baud_src),
  .uart1_baud_tick(uart1_baud_tick));

// file: tb/gpt_pin_model.sv
// Purpose: far-side pins: count pulses, gate and direction levels, oscillator
// Assumes: bench sets idle levels
// Notes: one pulse slot is 16 mclk, low for the last 8
`timescale 1ns/100ps
module gpt_pin_model import gpt_pkg::*; (
  // clock
  input wire logic mclk,
  input wire logic rst,
  // bench commands
  input wire logic [GPT_NPIN-1:0] idle_lvl,
  input wire logic [GPT_NPIN-1:0] pulse_sel,
  input wire logic [7:0] pulse_cnt,
  input wire logic go,
  // pins
  output logic [GPT_NPIN-1:0] pins
);
  // ****
  // pulse train
  // ****
  logic [7:0] left_r;
  logic [3:0] ph_r;
  logic [2:0] osc_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      left_r <= 8'h00;
      ph_r <= 4'h0;
    end else if (go) begin
      left_r <= pulse_cnt;
      ph_r <= 4'h0;
    end else if (left_r != 8'h00) begin
      ph_r <= ph_r + 4'h1;
      if (ph_r == 4'hF) begin
        left_r <= left_r - 8'h01;
      end
    end
  end
  // oscillator period 6 mclk, so ext/8 gives one tick per 48
  always_ff @(posedge mclk) begin
    osc_r <= (rst || osc_r == 3'h5) ? 3'h0 : osc_r + 3'h1;
  end
  // low phase of 8 keeps far above the 2-cycle filter limit
  always_comb begin
    pins = idle_lvl & ~(pulse_sel & {GPT_NPIN{left_r != 8'h00 && ph_r[3]}});
    pins[GPT_P_OSC] = osc_r < 3'h3;
  end
endmodule

// file: tb/gpt_timers_tb.sv
// Purpose: self-checking bench for the timer block
// Assumes: ce held high throughout
// Notes: pin edges come from the pin model
`timescale 1ns/100ps
module gpt_timers_tb import gpt_pkg::*; ;
  localparam logic [7:0] W0 = gpt_w_base[0];
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, v, pulse_cnt = 8'h00;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, run_a = 1'b0, run_b = 1'b0, clr_a = 1'b0, clr_b = 1'b0;
  logic ack_a = 1'b0, ack_b = 1'b0, go = 1'b0, flag_a, flag_b, baud1;
  logic [1:0] adc_trig;
  logic [2:0] dac_trig, tog;
  logic [3:0] baud0;
  logic [GPT_NPIN-1:0] idle_lvl = '1, pulse_sel = '0, pins;
  int bad_count = 0, total_checks = 0, n_b1 = 0, n_w0 = 0;
  int divs [4] = '{12, 4, 48, 48};
  int wdivs [4] = '{1, 2, 12, 48};
  always #5 mclk = ~mclk;
  gpt_timers gpt_timers_inst (.mclk(mclk), .rst(rst), .ce(1'b1), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer_a_run(run_a), .timer_b_run(run_b),
    .tf_a_clr(clr_a), .tf_b_clr(clr_b), .vec_a_ack(ack_a), .vec_b_ack(ack_b), .timer_a_overflow_flag(flag_a),
    .timer_b_overflow_flag(flag_b), .ext_osc_pin(pins[GPT_P_OSC]), .ext_irq_a_pin(pins[GPT_P_IRQA]),
    .ext_irq_b_pin(pins[GPT_P_IRQB]), .timer_a_count_pin(pins[GPT_P_CNTA]), .timer_b_count_pin(pins[GPT_P_CNTB]),
    .wide_timer_count_pin(pins[GPT_P_WCNT +: 3]), .wide_timer_trigger_pin(pins[GPT_P_WTRG +: 3]),
    .adc_start_trig(adc_trig), .dac_update_trig(dac_trig), .uart0_baud_src(baud0), .uart1_baud_tick(baud1),
    .wide_toggle_out(tog));
  gpt_pin_model gpt_pin_model_inst (.mclk(mclk), .rst(rst), .idle_lvl(idle_lvl), .pulse_sel(pulse_sel),
    .pulse_cnt(pulse_cnt), .go(go), .pins(pins));
  // event pulses stand one cycle, so counting on the falling edge sees each once
  always @(negedge mclk) begin
    if (baud1 && baud0 == 4'h1) n_b1++;
    if (dac_trig == 3'h1 && adc_trig == 2'h1 && baud0 == 4'h2) n_w0++;
  end
  // ****
  // tasks
  // ****
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge mclk);
    sfr_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge mclk);
    sfr_rd <= 1'b0;
    @(posedge mclk);
    v = sfr_rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_near(input logic [7:0] got, input int exp, input int tol);
    total_checks++;
    if ($isunknown(got) || got + tol < exp || got > exp + tol) begin
      bad_count++;
      $display("wrong value at %0t: got %0d, near %0d", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk(v, exp);
  endtask
  // waits out the whole train; slot timing is fixed by the pin model
  task automatic pulse(input int idx, input logic [7:0] n);
    pulse_sel <= GPT_NPIN'(1) << idx;
    pulse_cnt <= n;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (16 * n + 8) @(posedge mclk);
  endtask
  task automatic finish_test;
    if (bad_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    finish_test();
  end
  // ****
  // tests
  // ****
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int a = 8'h89; a <= 8'h8E; a++) rc(8'(a), GPT_RST_BYTE);
    rc(8'h80, 8'h00);
    wr(GPT_A_CKC, 8'hFF);
    rc(GPT_A_CKC, 8'h1B);
    wr(GPT_A_MODE, 8'hA5);
    rc(GPT_A_MODE, 8'hA5);
    wr(W0 + 8'h3, 8'hA5);
    rc(W0 + 8'h3, 8'hA5);
    wr(GPT_A_MODE, 8'h05);
    wr(GPT_A_TAL, 8'hFE);
    wr(GPT_A_TAH, 8'h00);
    run_a <= 1'b1;
    pulse(GPT_P_CNTA, 3);
    rc(GPT_A_TAL, 8'h01);
    rc(GPT_A_TAH, 8'h01);
    wr(GPT_A_MODE, 8'h0D);
    idle_lvl[GPT_P_IRQA] <= 1'b0;
    pulse(GPT_P_CNTA, 2);
    rc(GPT_A_TAL, 8'h01);
    idle_lvl[GPT_P_IRQA] <= 1'b1;
    pulse(GPT_P_CNTA, 2);
    rc(GPT_A_TAL, 8'h03);
    run_a <= 1'b0;
    pulse(GPT_P_CNTA, 1);
    rc(GPT_A_TAL, 8'h03);
    run_a <= 1'b1;
    wr(GPT_A_MODE, 8'h06);
    wr(GPT_A_TAH, 8'hF0);
    wr(GPT_A_TAL, 8'hFE);
    pulse(GPT_P_CNTA, 3);
    rc(GPT_A_TAL, 8'hF1);
    rc(GPT_A_TAH, 8'hF0);
    chk({7'h0, flag_a}, 8'h01);
    clr_a <= 1'b1;
    @(posedge mclk);
    clr_a <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({7'h0, flag_a}, 8'h00);
    wr(GPT_A_MODE, 8'h04);
    wr(GPT_A_TAH, 8'hFF);
    wr(GPT_A_TAL, 8'hFF);
    pulse(GPT_P_CNTA, 1);
    rc(GPT_A_TAL, 8'hE0);
    rc(GPT_A_TAH, 8'h00);
    chk({7'h0, flag_a}, 8'h01);
    ack_a <= 1'b1;
    @(posedge mclk);
    ack_a <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({7'h0, flag_a}, 8'h00);
    run_a <= 1'b0;
    run_b <= 1'b1;
    wr(GPT_A_MODE, 8'h70);
    wr(GPT_A_TBL, 8'h10);
    pulse(GPT_P_CNTB, 2);
    rc(GPT_A_TBL, 8'h10);
    wr(GPT_A_MODE, 8'h50);
    pulse(GPT_P_CNTB, 2);
    rc(GPT_A_TBL, 8'h12);
    wr(GPT_A_MODE, 8'h13);
    wr(GPT_A_TAH, 8'hFE);
    repeat (6) @(posedge mclk);
    chk({7'h0, flag_b}, 8'h01);
    clr_b <= 1'b1;
    @(posedge mclk);
    clr_b <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({7'h0, flag_b}, 8'h00);
    // the split high byte wraps every 256 cycles and sets the flag again
    repeat (256) @(posedge mclk);
    chk({7'h0, flag_b}, 8'h01);
    ack_b <= 1'b1;
    @(posedge mclk);
    ack_b <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({7'h0, flag_b}, 8'h00);
    run_b <= 1'b0;
    wr(GPT_A_MODE, 8'h01);
    for (int p = 0; p < 5; p++) begin
      wr(GPT_A_CKC, (p == 4) ? 8'h08 : 8'(p));
      wr(GPT_A_TAL, 8'h00);
      run_a <= 1'b1;
      repeat (p == 4 ? 200 : 480) @(posedge mclk);
      run_a <= 1'b0;
      rd(GPT_A_TAL);
      chk_near(v, (p == 4) ? 200 : 480 / divs[p], 2);
    end
    for (int c = 0; c < 4; c++) begin
      wr(W0 + 8'h1, 8'(c << 3));
      wr(W0 + 8'h2, 8'h00);
      wr(W0, 8'h04);
      repeat (96) @(posedge mclk);
      wr(W0, 8'h00);
      rd(W0 + 8'h2);
      chk_near(v, 96 / wdivs[c], 3);
    end
    wr(W0 + 8'h1, 8'h01);
    wr(W0 + 8'h2, 8'h05);
    wr(W0 + 8'h3, 8'h00);
    idle_lvl[GPT_P_WTRG] <= 1'b0;
    wr(W0, 8'h0E);
    pulse(GPT_P_WCNT, 2);
    rc(W0 + 8'h2, 8'h03);
    idle_lvl[GPT_P_WTRG] <= 1'b1;
    pulse(GPT_P_WCNT, 3);
    rc(W0 + 8'h2, 8'h06);
    pulse(GPT_P_WTRG, 1);
    rc(W0, 8'h0E);
    rc(W0 + 8'h2, 8'h06);
    wr(GPT_A_CKC, 8'h10);
    wr(GPT_A_MODE, 8'h21);
    wr(GPT_A_TBH, 8'hF0);
    wr(GPT_A_TBL, 8'hF0);
    run_b <= 1'b1;
    repeat (160) @(posedge mclk);
    run_b <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(8'(n_b1), 8'h0A);
    rc(GPT_A_TBL, 8'hF0);
    wr(W0, 8'h00);
    wr(W0 + 8'h1, 8'h02);
    wr(W0 + 8'h4, 8'hF0);
    wr(W0 + 8'h5, 8'hFF);
    wr(W0 + 8'h2, 8'hF0);
    wr(W0 + 8'h3, 8'hFF);
    wr(W0, 8'h04);
    repeat (142) @(posedge mclk);
    wr(W0, 8'h00);
    repeat (2) @(posedge mclk);
    chk(8'(n_w0), 8'h09);
    chk({5'h0, tog}, 8'h01);
    rc(W0 + 8'h2, 8'hF0);
    finish_test();
  end
endmodule
